// [core/pbaoc_top.sv]
// phase build-out sequencer, trim, output skew, acceptance range and reference qualification
// assumes all non-bus inputs come from DPLL and monitor logic on mclk
`timescale 1ns/1ps
`default_nettype none
module pbaoc_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dpll_locked,
	input wire logic ref_switch,
	input wire logic phase_jump,
	input wire logic [15:0] phase_meas,
	input wire logic [1:0] sel_ref,
	input wire logic lock_lost,
	input wire logic [3:0] ref_off_range,
	input wire logic [3:0] ref_eye_closed,
	input wire logic [3:0] ref_gap,
	input wire logic [3:0] ref_lost,
	output logic holdover_req,
	output logic [17:0] absorb_offset,
	output logic [15:0] feedback_shift,
	output logic slew_active,
	output logic [3:0] ref_usable,
	output logic rearrange_req,
	output logic [9:0] accept_range,
	output logic irq
);
	typedef struct packed {
		pbaoc_pkg::pbaoc_fsm_e st;
		logic [7:0] ctrl;
		logic [7:0] autoj;
		logic [15:0] skew;
		logic [7:0] trim;
		logic [9:0] range;
		logic [3:0] bw;
		logic [3:0] ist;
		logic [3:0] imask;
		logic [31:0] rdata;
		logic en_prev;
		logic [11:0] hcnt;
		logic signed [15:0] meas;
		logic signed [17:0] offs;
		logic [15:0] scnt;
		logic slew;
		logic [15:0] fb;
		logic [3:0] fail;
		logic [3:0][11:0] bad_cnt;
		logic [3:0][11:0] gap_cnt;
		logic [3:0] gap_seen;
		logic [3:0][11:0] good_cnt;
		logic rearr;
	} pbaoc_state_s;

	pbaoc_state_s q;
	pbaoc_state_s d;
	logic [7:0] idx;
	logic mapped;
	logic [31:0] rmux;

	// address decode and read multiplexer
	always_comb begin
		idx = paddr[9:2];
		mapped = (paddr[1:0] == 2'h0);
		rmux = 32'h0;
		case (idx)
			pbaoc_pkg::IDX_CTRL: rmux = {24'h0, q.ctrl};
			pbaoc_pkg::IDX_AUTO: rmux = {24'h0, q.autoj};
			pbaoc_pkg::IDX_SKEW_LO: rmux = {24'h0, q.skew[7:0]};
			pbaoc_pkg::IDX_SKEW_HI: rmux = {24'h0, q.skew[15:8]};
			pbaoc_pkg::IDX_TRIM: rmux = {24'h0, q.trim};
			pbaoc_pkg::IDX_RANGE: rmux = {22'h0, q.range};
			pbaoc_pkg::IDX_BW: rmux = {28'h0, q.bw};
			pbaoc_pkg::IDX_STATE: rmux = {26'h0, q.slew, dpll_locked, q.st};
			pbaoc_pkg::IDX_FAIL: rmux = {28'h0, q.fail};
			pbaoc_pkg::IDX_ISTAT: rmux = {28'h0, q.ist};
			pbaoc_pkg::IDX_IMASK: rmux = {28'h0, q.imask};
			pbaoc_pkg::IDX_OFFSET: rmux = {14'h0, q.offs};
			default: mapped = 1'b0;
		endcase
	end

	logic wr;
	logic rd_acc;
	logic trig;
	logic signed [7:0] trim_c;
	// signed limit, so a negative trim is compared as negative
	localparam logic signed [7:0] TRIM_HI = 8'(pbaoc_pkg::TRIM_MAX);
	logic [15:0] period;
	logic [3:0] newfail;
	logic [3:0] requal;
	logic slow;
	logic fail_now;
	logic ev_done;
	logic ev_slew;

	// next-state logic for the whole block
	always_comb begin
		d = q;
		wr = psel & penable & pwrite & mapped;
		rd_acc = psel & penable & ~pwrite & mapped;
		newfail = 4'h0;
		requal = 4'h0;
		slow = 1'b0;
		fail_now = 1'b0;
		ev_done = 1'b0;
		ev_slew = 1'b0;
		period = 16'h1 << q.bw;
		// trim saturates at the documented span, signed
		if ($signed(q.trim) > TRIM_HI) begin
			trim_c = TRIM_HI;
		end else if ($signed(q.trim) < -TRIM_HI) begin
			trim_c = -TRIM_HI;
		end else begin
			trim_c = q.trim;
		end

		// register writes
		if (wr) begin
			case (idx)
				pbaoc_pkg::IDX_CTRL: d.ctrl = pwdata[7:0];
				pbaoc_pkg::IDX_AUTO: d.autoj = pwdata[7:0];
				pbaoc_pkg::IDX_SKEW_LO: d.skew[7:0] = pwdata[7:0];
				pbaoc_pkg::IDX_SKEW_HI: d.skew[15:8] = pwdata[7:0];
				pbaoc_pkg::IDX_TRIM: d.trim = pwdata[7:0];
				pbaoc_pkg::IDX_RANGE: d.range = (pwdata[9:0] > pbaoc_pkg::RANGE_MAX) ?
					pbaoc_pkg::RANGE_MAX : pwdata[9:0];
				pbaoc_pkg::IDX_BW: d.bw = pwdata[3:0];
				pbaoc_pkg::IDX_IMASK: d.imask = pwdata[3:0];
				default: d.ctrl = q.ctrl;
			endcase
		end
		// read data is captured in the setup phase
		if (psel & ~penable) begin
			d.rdata = rmux;
		end

		// build-out trigger: reference switch, phase jump, or enable while locked
		d.en_prev = q.ctrl[pbaoc_pkg::CTRL_EN_BIT];
		trig = (q.ctrl[pbaoc_pkg::CTRL_EN_BIT] & ~q.en_prev & dpll_locked)
			| (ref_switch & q.ctrl[pbaoc_pkg::CTRL_EN_BIT])
			| (phase_jump & q.autoj[pbaoc_pkg::AUTO_JUMP_BIT]);
		case (q.st)
			pbaoc_pkg::ST_IDLE: begin
				// frozen ignores new events; the offset still slews to zero if build-out is disabled while locked
				if (trig & ~q.ctrl[pbaoc_pkg::CTRL_FRZ_BIT]) begin
					d.st = pbaoc_pkg::ST_HOLD;
					d.hcnt = 12'h0;
				end
			end
			pbaoc_pkg::ST_HOLD: begin
				// temporary holdover while the new input settles
				if (q.hcnt == pbaoc_pkg::HOLD_CYC - 12'h1) begin
					d.st = pbaoc_pkg::ST_MEAS;
				end else begin
					d.hcnt = q.hcnt + 12'h1;
				end
			end
			pbaoc_pkg::ST_MEAS: begin
				d.meas = phase_meas;
				d.st = pbaoc_pkg::ST_APPLY;
			end
			pbaoc_pkg::ST_APPLY: begin
				// compensating offset plus signed trim
				d.offs = q.offs + 18'(q.meas) + 18'(trim_c);
				d.st = pbaoc_pkg::ST_IDLE;
				ev_done = 1'b1;
			end
			default: d.st = pbaoc_pkg::ST_IDLE;
		endcase

		// disabled while locked: walk the offset back to zero at the bandwidth rate
		d.slew = 1'b0;
		if (~q.ctrl[pbaoc_pkg::CTRL_EN_BIT] && dpll_locked && q.offs != 18'sh0
			&& q.st == pbaoc_pkg::ST_IDLE) begin
			d.slew = 1'b1;
			if (q.scnt >= period - 16'h1) begin
				d.scnt = 16'h0;
				d.offs = (q.offs > 18'sh0) ? q.offs - 18'sh1 : q.offs + 18'sh1;
				ev_slew = (q.offs == 18'sh1) || (q.offs == -18'sh1);
			end else begin
				d.scnt = q.scnt + 16'h1;
			end
		end else begin
			d.scnt = 16'h0;
		end

		// skew moves the feedback clock only with build-out fully off
		d.fb = (~q.ctrl[pbaoc_pkg::CTRL_EN_BIT] & ~q.autoj[pbaoc_pkg::AUTO_JUMP_BIT]) ?
			q.skew : 16'h0;

		// per-reference quality monitor
		for (int i = 0; i < pbaoc_pkg::NREF; i++) begin
			slow = ref_off_range[i] | ref_lost[i];
			if (slow) begin
				d.bad_cnt[i] = (q.bad_cnt[i] == pbaoc_pkg::DETECT_CYC) ?
					q.bad_cnt[i] : q.bad_cnt[i] + 12'h1;
			end else begin
				d.bad_cnt[i] = 12'h0;
			end
			// a lone gap only opens a watch window
			if (q.gap_seen[i]) begin
				if (q.gap_cnt[i] == pbaoc_pkg::GAP_WIN_CYC) begin
					d.gap_seen[i] = 1'b0;
				end else begin
					d.gap_cnt[i] = q.gap_cnt[i] + 12'h1;
				end
			end
			if (ref_gap[i] & ~q.gap_seen[i]) begin
				d.gap_seen[i] = 1'b1;
				d.gap_cnt[i] = 12'h0;
			end
			fail_now = ref_eye_closed[i]
				| (slow & (q.bad_cnt[i] == pbaoc_pkg::DETECT_CYC))
				| (ref_gap[i] & q.gap_seen[i])
				| (lock_lost & (sel_ref == 2'(i)));
			if (fail_now) begin
				newfail[i] = ~q.fail[i];
				d.fail[i] = 1'b1;
				d.good_cnt[i] = 12'h0;
			end else if (q.fail[i]) begin
				// requalify only after a clean stretch
				if (slow | ref_gap[i]) begin
					d.good_cnt[i] = 12'h0;
				end else if (q.good_cnt[i] == pbaoc_pkg::QUAL_CYC) begin
					d.fail[i] = 1'b0;
					requal[i] = 1'b1;
				end else begin
					d.good_cnt[i] = q.good_cnt[i] + 12'h1;
				end
			end
		end
		d.rearr = |(newfail & (4'h1 << sel_ref));

		// sticky status: read clears reported bits, a new event wins
		if (rd_acc && idx == pbaoc_pkg::IDX_ISTAT) begin
			d.ist = q.ist & ~q.rdata[3:0];
		end
		d.ist[pbaoc_pkg::IRQ_DONE] = d.ist[pbaoc_pkg::IRQ_DONE] | ev_done;
		d.ist[pbaoc_pkg::IRQ_FAIL] = d.ist[pbaoc_pkg::IRQ_FAIL] | (|newfail);
		d.ist[pbaoc_pkg::IRQ_REQUAL] = d.ist[pbaoc_pkg::IRQ_REQUAL] | (|requal);
		d.ist[pbaoc_pkg::IRQ_SLEW] = d.ist[pbaoc_pkg::IRQ_SLEW] | ev_slew;
	end

	// state register; build-out enabled after reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
			q.st <= pbaoc_pkg::ST_IDLE;
			q.ctrl <= pbaoc_pkg::CTRL_RST;
			q.en_prev <= 1'b1;
			q.range <= pbaoc_pkg::RANGE_RST;
			q.bw <= pbaoc_pkg::BW_RST;
		end else begin
			q <= d;
		end
	end

	// outputs
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = q.rdata;
	assign holdover_req = (q.st == pbaoc_pkg::ST_HOLD);
	assign absorb_offset = q.offs;
	assign feedback_shift = q.fb;
	assign slew_active = q.slew;
	assign ref_usable = ~q.fail;
	assign rearrange_req = q.rearr;
	assign accept_range = q.range;
	assign irq = |(q.ist & q.imask);

	// checks
	localparam int A_HOLD = int'(pbaoc_pkg::HOLD_CYC);
	localparam int A_TRIM = pbaoc_pkg::TRIM_MAX;
	logic signed [17:0] a_offs_prev;
	logic signed [15:0] a_meas_prev;
	logic signed [17:0] a_step;
	always_ff @(posedge mclk) begin
		a_offs_prev <= q.offs;
		a_meas_prev <= q.meas;
	end
	assign a_step = q.offs - a_offs_prev - 18'(a_meas_prev);

	default clocking a_cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_idle_enable;
		q.st == pbaoc_pkg::ST_IDLE && q.ctrl[pbaoc_pkg::CTRL_EN_BIT] && !q.en_prev
			&& dpll_locked && !q.ctrl[pbaoc_pkg::CTRL_FRZ_BIT];
	endsequence
	sequence s_measure_apply;
		##A_HOLD (q.st == pbaoc_pkg::ST_MEAS) ##1 (q.st == pbaoc_pkg::ST_APPLY)
			##1 (q.st == pbaoc_pkg::ST_IDLE);
	endsequence
	sequence s_lone_gap;
		ref_gap[3] && !q.gap_seen[3] && !q.fail[3] && !ref_eye_closed[3] && !ref_off_range[3]
			&& !ref_lost[3] && !(lock_lost && sel_ref == 2'h3);
	endsequence

	property p_enable_event;
		s_idle_enable |=> holdover_req;
	endproperty
	a_enable_event: assert property (p_enable_event) else $error("enable did not start build-out");
	property p_hold_len;
		$rose(holdover_req) |-> s_measure_apply;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("build-out sequence timing wrong");
	property p_freeze;
		(q.ctrl[pbaoc_pkg::CTRL_FRZ_BIT] && q.st == pbaoc_pkg::ST_IDLE) |=> !holdover_req;
	endproperty
	a_freeze: assert property (p_freeze) else $error("frozen build-out took an event");
	property p_trim;
		$past(q.st == pbaoc_pkg::ST_APPLY) |-> (a_step <= A_TRIM && a_step >= -A_TRIM);
	endproperty
	a_trim: assert property (p_trim) else $error("trim outside limit");
	property p_skew_gate;
		feedback_shift != 16'h0 |->
			$past(!q.ctrl[pbaoc_pkg::CTRL_EN_BIT] && !q.autoj[pbaoc_pkg::AUTO_JUMP_BIT]);
	endproperty
	a_skew_gate: assert property (p_skew_gate) else $error("skew used with build-out on");
	property p_slew;
		(!q.ctrl[pbaoc_pkg::CTRL_EN_BIT] && dpll_locked && q.st == pbaoc_pkg::ST_IDLE
			&& q.offs > 18'sh0) |=> (q.offs <= $past(q.offs) && q.offs >= $past(q.offs) - 18'sh1);
	endproperty
	a_slew: assert property (p_slew) else $error("offset did not slew toward zero");
	property p_range;
		accept_range <= pbaoc_pkg::RANGE_MAX;
	endproperty
	a_range: assert property (p_range) else $error("acceptance range above limit");
	property p_eye;
		(|ref_eye_closed) |=> (ref_usable & $past(ref_eye_closed)) == 4'h0;
	endproperty
	a_eye: assert property (p_eye) else $error("eye-closed reference kept");
	property p_excluded;
		(!ref_usable[0] && (ref_off_range[0] || ref_lost[0])) |=> !ref_usable[0] [*2];
	endproperty
	a_excluded: assert property (p_excluded) else $error("bad reference requalified");
	property p_lone_gap;
		s_lone_gap |=> ref_usable[3] && !rearrange_req;
	endproperty
	a_lone_gap: assert property (p_lone_gap) else $error("single gap caused failure");
	property p_repeat_gap;
		(ref_gap[3] && q.gap_seen[3]) |=> !ref_usable[3];
	endproperty
	a_repeat_gap: assert property (p_repeat_gap) else $error("repeated gap not failed");
endmodule // pbaoc_top
`default_nettype wire

// [core/pbaoc_pkg.sv]
// constants, register indices and types for the phase build-out and offset control block
// assumes a single 250 MHz system clock and a 32-bit APB register port
//
// Summary of operation
// - enabling build-out while locked raises an event
// - disabling build-out while locked slews offset to zero
// - build-out trim in 0.101 ns steps
// - build-out trim limited to plus/minus 1.4 ns
// - output skew in 6 ps steps, both signs
// - skew applied through the feedback clock phase
// - skew only used while build-out fully off
// - reject reference out of range or eye-closed
// - repeated or long interruptions force rearrangement
// - failed reference excluded until quality recovers
// - acceptance range default 9.2, 0 to 80 ppm
// - event: temporary holdover, measure, add offset
// - build-out enabled at reset, can be frozen
package pbaoc_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int NREF = 4;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_RANGE = 8'h60;
	localparam logic [7:0] IDX_BW = 8'h61;
	localparam logic [7:0] IDX_STATE = 8'h62;
	localparam logic [7:0] IDX_FAIL = 8'h63;
	localparam logic [7:0] IDX_ISTAT = 8'h64;
	localparam logic [7:0] IDX_IMASK = 8'h65;
	localparam logic [7:0] IDX_OFFSET = 8'h66;
	localparam logic [7:0] IDX_CTRL = 8'h48;
	localparam logic [7:0] IDX_SKEW_LO = 8'h70;
	localparam logic [7:0] IDX_SKEW_HI = 8'h71;
	localparam logic [7:0] IDX_TRIM = 8'h72;
	localparam logic [7:0] IDX_AUTO = 8'h76;

	// field positions
	localparam int CTRL_EN_BIT = 2;
	localparam int CTRL_FRZ_BIT = 3;
	localparam int AUTO_JUMP_BIT = 4;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_REQUAL = 2;
	localparam int IRQ_SLEW = 3;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h04;
	localparam logic [3:0] BW_RST = 4'h4;

	// trim: 0.101 ns steps, limited to 1.4 ns
	localparam int TRIM_STEP_PS = 101;
	localparam int TRIM_LIMIT_PS = 1400;
	localparam int TRIM_MAX = TRIM_LIMIT_PS / TRIM_STEP_PS;

	// acceptance range in 0.08 ppm steps
	localparam int RANGE_STEP_PPB = 80;
	localparam int RANGE_DFLT_PPB = 9200;
	localparam int RANGE_LIMIT_PPB = 80000;
	localparam logic [9:0] RANGE_RST = 10'(RANGE_DFLT_PPB / RANGE_STEP_PPB);
	localparam logic [9:0] RANGE_MAX = 10'(RANGE_LIMIT_PPB / RANGE_STEP_PPB);

	// timing: least times round up, the gap window rounds down
	localparam int HOLD_NS = 1000;
	localparam int DETECT_NS = 8000;
	localparam int GAP_WIN_NS = 16000;
	localparam int QUAL_NS = 16000;
	localparam logic [11:0] HOLD_CYC = 12'((HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [11:0] DETECT_CYC = 12'((DETECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [11:0] GAP_WIN_CYC = 12'(GAP_WIN_NS * 1000 / CLK_PERIOD_PS);
	localparam logic [11:0] QUAL_CYC = 12'((QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// build-out sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HOLD = 4'h2,
		ST_MEAS = 4'h4,
		ST_APPLY = 4'h8
	} pbaoc_fsm_e;
endpackage

// [dv/pbaoc_ref_model.sv]
// reference source model: turns bench fault commands into monitor flags
// assumes commands change right after mclk rising edges
`timescale 1ns/1ps
`default_nettype none
module pbaoc_ref_model (
	input wire logic mclk,
	input wire logic [3:0] eye_cmd,
	input wire logic [3:0] off_cmd,
	input wire logic [3:0] gap_cmd,
	input wire logic [3:0] lost_cmd,
	output logic [3:0] ref_off_range = '0,
	output logic [3:0] ref_eye_closed = '0,
	output logic [3:0] ref_gap = '0,
	output logic [3:0] ref_lost = '0
);
	logic [3:0] gap_q = '0;
	// flags follow commands one edge later; a gap is one pulse per command rise
	always @(posedge mclk) begin
		ref_off_range <= off_cmd;
		ref_eye_closed <= eye_cmd;
		ref_lost <= lost_cmd;
		ref_gap <= gap_cmd & ~gap_q;
		gap_q <= gap_cmd;
	end
endmodule // pbaoc_ref_model
`default_nettype wire

// [dv/pbaoc_top_tb_top.sv]
// self-checking bench for build-out, trim, skew, range and reference qualification
// assumes zero-wait APB answers and a single mclk domain
`timescale 1ns/1ps
`default_nettype none
module pbaoc_top_tb_top;
	logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, dpll_locked = 0;
	logic ref_switch = 0, phase_jump = 0, pready, pslverr, holdover_req, slew_active;
	logic rearrange_req, irq, lock_lost = 0;
	logic [9:0] paddr = '0, accept_range;
	logic [31:0] pwdata = '0, prdata;
	logic [15:0] phase_meas = '0, feedback_shift, s;
	logic [1:0] sel_ref = '0;
	logic [3:0] eye_cmd = '0, off_cmd = '0, gap_cmd = '0, lost_cmd = '0, ref_usable;
	logic [3:0] ref_off_range, ref_eye_closed, ref_gap, ref_lost;
	logic [17:0] absorb_offset, exp_off = '0;
	logic [32:0] exp_q[$];
	int error_cnt = 0, comparisons = 0, n;

	// 250 MHz clock
	always #2 mclk = ~mclk;

	pbaoc_top u_pbaoc_top (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dpll_locked(dpll_locked), .ref_switch(ref_switch),
		.phase_jump(phase_jump), .phase_meas(phase_meas), .sel_ref(sel_ref),
		.lock_lost(lock_lost), .ref_off_range(ref_off_range), .ref_eye_closed(ref_eye_closed),
		.ref_gap(ref_gap), .ref_lost(ref_lost), .holdover_req(holdover_req),
		.absorb_offset(absorb_offset), .feedback_shift(feedback_shift),
		.slew_active(slew_active), .ref_usable(ref_usable), .rearrange_req(rearrange_req),
		.accept_range(accept_range), .irq(irq));

	pbaoc_ref_model u_pbaoc_ref_model (.mclk(mclk), .eye_cmd(eye_cmd), .off_cmd(off_cmd),
		.gap_cmd(gap_cmd), .lost_cmd(lost_cmd), .ref_off_range(ref_off_range),
		.ref_eye_closed(ref_eye_closed), .ref_gap(ref_gap), .ref_lost(ref_lost));

	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// wait k edges, then step past the edge so outputs have settled
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// one apb transfer; a read leaves {slverr, data} expected on the queue
	task automatic apb(input logic w, input logic [7:0] idx, input logic [32:0] d);
		int c;
		if (!w) exp_q.push_back(d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d[31:0];
		@(posedge mclk);
		penable <= 1;
		c = 0;
		do begin
			@(posedge mclk);
			c++;
		end while (pready !== 1 && c < 50);
		psel <= 0;
		penable <= 0;
	endtask

	// compare each completed read with the oldest expected word
	always @(posedge mclk) begin
		if (psel && penable && pready && !pwrite) begin
			chk({pslverr, prdata}, exp_q.pop_front(), "read");
		end
	end

	// one build-out event: 0 reference switch, 1 enable while locked, 2 phase jump
	task automatic bo_event(input int kind, input logic [7:0] t);
		logic signed [7:0] ts;
		logic signed [15:0] m;
		int c;
		ts = t;
		m = 16'($urandom_range(400)) - 16'sd200;
		apb(1, pbaoc_pkg::IDX_TRIM, {25'h0, t});
		@(posedge mclk);
		phase_meas <= m;
		ref_switch <= (kind == 0);
		phase_jump <= (kind == 2);
		if (kind == 1) apb(1, pbaoc_pkg::IDX_CTRL, 33'h4);
		@(posedge mclk);
		ref_switch <= 0;
		phase_jump <= 0;
		c = 0;
		#1;
		while (holdover_req !== 1 && c < 10) begin
			tick(1);
			c++;
		end
		c = 0;
		while (holdover_req === 1 && c < 300) begin
			tick(1);
			c++;
		end
		chk(c, 250, "holdover length");
		if (ts > 13) ts = 13;
		if (ts < -13) ts = -13;
		exp_off = exp_off + 18'(m) + 18'(ts);
		tick(2);
		chk(absorb_offset, exp_off, "offset");
		apb(0, pbaoc_pkg::IDX_ISTAT, 33'h1);
	endtask

	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end

	initial begin
		void'($urandom(32'ha4164a5b));
		repeat (2) @(posedge mclk);
		rst <= 0;
		apb(0, pbaoc_pkg::IDX_CTRL, 33'h4);
		apb(0, pbaoc_pkg::IDX_RANGE, 33'h73);
		apb(1, pbaoc_pkg::IDX_RANGE, 33'h3ff);
		apb(0, pbaoc_pkg::IDX_RANGE, 33'h3e8);
		apb(0, 8'hff, 33'h100000000);
		tick(1);
		chk(accept_range, 10'h3e8, "range");
		$display("test registers done");
		dpll_locked <= 1;
		bo_event(0, 8'h7f);
		bo_event(0, 8'h80);
		bo_event(0, 8'($urandom));
		$display("test build-out done");
		apb(1, pbaoc_pkg::IDX_CTRL, 33'hc);
		@(posedge mclk);
		ref_switch <= 1;
		@(posedge mclk);
		ref_switch <= 0;
		tick(3);
		chk(holdover_req, 0, "frozen hold");
		chk(absorb_offset, exp_off, "frozen offset");
		$display("test freeze done");
		apb(1, pbaoc_pkg::IDX_BW, 33'h0);
		apb(1, pbaoc_pkg::IDX_CTRL, 33'h0);
		tick(3);
		chk(slew_active, 1, "slew on");
		n = 0;
		while (absorb_offset !== 0 && n < 3000) begin
			tick(1);
			n++;
		end
		tick(3);
		chk(absorb_offset, 0, "slew end");
		chk(slew_active, 0, "slew off");
		exp_off = 0;
		apb(0, pbaoc_pkg::IDX_ISTAT, 33'h8);
		bo_event(1, 8'($urandom));
		$display("test slew and enable done");
		// software owns loop mode choices for big steps and jitter
		dpll_locked <= 0;
		apb(1, pbaoc_pkg::IDX_CTRL, 33'h0);
		s = {1'b1, 15'($urandom)};
		apb(1, pbaoc_pkg::IDX_SKEW_LO, {25'h0, s[7:0]});
		apb(1, pbaoc_pkg::IDX_SKEW_HI, {25'h0, s[15:8]});
		tick(2);
		chk(feedback_shift, s, "skew");
		apb(1, pbaoc_pkg::IDX_AUTO, 33'h10);
		tick(2);
		chk(feedback_shift, 0, "skew gated");
		bo_event(2, 8'($urandom));
		$display("test skew done");
		sel_ref <= 1;
		apb(1, pbaoc_pkg::IDX_IMASK, 33'h2);
		@(posedge mclk);
		eye_cmd <= 4'h2;
		n = 0;
		while (rearrange_req !== 1 && n < 10) begin
			tick(1);
			n++;
		end
		chk(n < 10, 1, "rearrange");
		chk(ref_usable, 4'hd, "eye fail");
		chk(irq, 1, "irq");
		eye_cmd <= 4'h0;
		off_cmd <= 4'h4;
		lost_cmd <= 4'h1;
		tick(1900);
		chk(ref_usable, 4'hd, "off early");
		tick(200);
		chk(ref_usable, 4'h8, "off late");
		@(posedge mclk);
		off_cmd <= 4'h0;
		lost_cmd <= 4'h0;
		repeat (2) begin
			gap_cmd <= 4'h8;
			@(posedge mclk);
			gap_cmd <= 4'h0;
			tick(3);
			chk(ref_usable[3], n < 10, "gap");
			n = 10;
			tick(100);
		end
		tick(4200);
		chk(ref_usable, 4'hf, "requalify");
		apb(0, pbaoc_pkg::IDX_ISTAT, 33'h6);
		tick(2);
		chk(irq, 0, "irq clear");
		// loss of lock fails the selected reference
		@(posedge mclk);
		lock_lost <= 1;
		@(posedge mclk);
		lock_lost <= 0;
		tick(2);
		chk(ref_usable, 4'hd, "lock lost");
		$display("test references done");
		end_sim();
	end
endmodule // pbaoc_top_tb_top
`default_nettype wire
